// *** ext_irq_cfg.svh ***
// offsets, field positions, reset values for the external irq register slice
`ifndef EXT_IRQ_CFG_SVH
`define EXT_IRQ_CFG_SVH
`define EIC_OFF_CTRL 8'h00
`define EIC_OFF_PERIPH_A 8'h04
`define EIC_OFF_PERIPH_B 8'h08
`define EIC_OFF_PERIPH_C 8'h0C
`define EIC_OFF_STATUS 8'h10
`define EIC_OFF_MASK 8'h14
`define EIC_BIT_EXT2_PRIO 7
`define EIC_BIT_EXT1_PRIO 6
`define EIC_BIT_EXT2_EN 4
`define EIC_BIT_EXT1_EN 3
`define EIC_BIT_EXT2_PEND 1
`define EIC_BIT_EXT1_PEND 0
`define EIC_CTRL_RESET 8'hC0
`define EIC_CTRL_WMASK 8'hDB
`define EIC_RESP_OKAY 2'h0
`define EIC_RESP_SLVERR 2'h2
`endif

// *** ext_irq_pkg.sv ***
// types for the external irq register slice
`default_nettype none
package ext_irq_pkg;
   typedef struct packed {
      logic ext2;
      logic ext1;
   } ext_pair_t;
   typedef struct packed {
      logic high;
      logic low;
   } prio_req_t;
endpackage
`default_nettype wire

// *** ext_irq_ctrl_bank.sv ***
// external interrupt priority/enable/flag register bank with axi4-lite slave
//=============================================================
// Summary of operation
// R1 - Control register holds enable bits for both external inputs, reset 0.
// R2 - Disabled input raises no request, but its pending flag still records; its status bit still raises irq when its mask bit is set.
// R3 - Each input has pending flag set by event, cleared only by writing 0.
// R4 - Control bits 5 and 2 ignore writes and read as 0.
// R5 - All flags set on their condition regardless of any enable.
// R6 - Software should clear a flag before enabling its interrupt.
// R7 - Software should clear peripheral flags before enabling and after service.
// R8 - Three eight-bit peripheral request flag registers, one bit per source.
// R9 - Top two control bits pick priority per input, 1 high, reset 1.
//
// Decided for this implementation: the address map and register access over AXI4-Lite.
`timescale 1ns/10ps
`default_nettype none
`include "ext_irq_cfg.svh"
module ext_irq_ctrl_bank #(
   parameter int PERIPH_W = 8
) (
   // clock and reset
   input wire logic clock,
   input wire logic nrst,
   // external interrupt pins, asynchronous
   input wire ext_irq_pkg::ext_pair_t ext_pin,
   // peripheral event pulses, core clock domain
   input wire logic [PERIPH_W-1:0] periph_event_a,
   input wire logic [PERIPH_W-1:0] periph_event_b,
   input wire logic [PERIPH_W-1:0] periph_event_c,
   // priority request outputs
   output ext_irq_pkg::prio_req_t ext_req,
   // summary interrupt
   output logic irq,
   // axi4-lite slave
   input wire logic [7:0] s_awaddr,
   input wire logic s_awvalid,
   output logic s_awready,
   input wire logic [31:0] s_wdata,
   input wire logic [3:0] s_wstrb,
   input wire logic s_wvalid,
   output logic s_wready,
   output logic [1:0] s_bresp,
   output logic s_bvalid,
   input wire logic s_bready,
   input wire logic [7:0] s_araddr,
   input wire logic s_arvalid,
   output logic s_arready,
   output logic [31:0] s_rdata,
   output logic [1:0] s_rresp,
   output logic s_rvalid,
   input wire logic s_rready
);
   import ext_irq_pkg::*;

   // elaboration guard: bus lane 0 and the register bytes are fixed at eight bits
   if (PERIPH_W != 8) begin : bad_width
      $error("peripheral flag registers are eight bits");
   end

   //=============================================================
   // pin synchronisers and rising-edge detection
   // the third flop only remembers the last synced level for the edge detector
   ext_pair_t sync1_reg, sync2_reg, sync3_reg;
   ext_pair_t ext_event;
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         sync1_reg <= '0;
         sync2_reg <= '0;
         sync3_reg <= '0;
      end else begin
         sync1_reg <= ext_pin;
         sync2_reg <= sync1_reg;
         sync3_reg <= sync2_reg;
      end
   end
   // edge polarity lives elsewhere; rising edge assumed here
   assign ext_event = sync2_reg & ~sync3_reg;

   //=============================================================
   // axi4-lite write channel
   logic aw_held_reg, w_held_reg;
   logic [7:0] awaddr_reg;
   logic [31:0] wdata_reg;
   logic [3:0] wstrb_reg;
   logic wr_go;
   // aw and w are held apart, so they may arrive in either order
   assign s_awready = !aw_held_reg && !s_bvalid;
   assign s_wready = !w_held_reg && !s_bvalid;
   assign wr_go = aw_held_reg && w_held_reg && !s_bvalid;
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         aw_held_reg <= 1'b0;
         w_held_reg <= 1'b0;
         awaddr_reg <= 8'h00;
         wdata_reg <= 32'h0000_0000;
         wstrb_reg <= 4'h0;
         s_bvalid <= 1'b0;
         s_bresp <= `EIC_RESP_OKAY;
      end else begin
         if (s_awvalid && s_awready) begin
            aw_held_reg <= 1'b1;
            awaddr_reg <= s_awaddr;
         end
         if (s_wvalid && s_wready) begin
            w_held_reg <= 1'b1;
            wdata_reg <= s_wdata;
            wstrb_reg <= s_wstrb;
         end
         if (wr_go) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            s_bvalid <= 1'b1;
            s_bresp <= addr_ok(awaddr_reg) ? `EIC_RESP_OKAY : `EIC_RESP_SLVERR;
         end else if (s_bvalid && s_bready) begin
            s_bvalid <= 1'b0;
         end
      end
   end

   function automatic logic addr_ok(input logic [7:0] a);
      case (a)
         `EIC_OFF_CTRL, `EIC_OFF_PERIPH_A, `EIC_OFF_PERIPH_B,
         `EIC_OFF_PERIPH_C, `EIC_OFF_STATUS, `EIC_OFF_MASK: addr_ok = 1'b1;
         default: addr_ok = 1'b0;
      endcase
   endfunction

   // only byte lane 0 carries register data
   logic wr_lane0;
   assign wr_lane0 = wr_go && wstrb_reg[0];
   logic [7:0] wbyte;
   assign wbyte = wdata_reg[7:0];

   //=============================================================
   // control register: priority, enable, pending
   // a one written to a pending bit sets it, which lets software test the path
   logic [7:0] ctrl_reg;
   logic wr_ctrl;
   assign wr_ctrl = wr_lane0 && (awaddr_reg == `EIC_OFF_CTRL);
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         ctrl_reg <= `EIC_CTRL_RESET; // R1 R9
      end else begin
         if (wr_ctrl) begin
            // unimplemented bits masked off
            ctrl_reg <= wbyte & `EIC_CTRL_WMASK; // R1 R4 R9
         end
         // set wins over software clear, enable not consulted
         if (ext_event.ext2) ctrl_reg[`EIC_BIT_EXT2_PEND] <= 1'b1; // R3 R5
         if (ext_event.ext1) ctrl_reg[`EIC_BIT_EXT1_PEND] <= 1'b1; // R3 R5
      end
   end

   //=============================================================
   // peripheral request flag registers, one generate per bank
   logic [PERIPH_W-1:0] pflag_reg [3];
   logic [PERIPH_W-1:0] pevent [3];
   logic [7:0] poff [3];
   assign pevent[0] = periph_event_a;
   assign pevent[1] = periph_event_b;
   assign pevent[2] = periph_event_c;
   assign poff[0] = `EIC_OFF_PERIPH_A;
   assign poff[1] = `EIC_OFF_PERIPH_B;
   assign poff[2] = `EIC_OFF_PERIPH_C;
   genvar g;
   generate
      for (g = 0; g < 3; g++) begin : pbank
         always_ff @(posedge clock or negedge nrst) begin
            if (!nrst) begin
               pflag_reg[g] <= '0;
            end else begin
               // software writes, events set on top so none is lost
               pflag_reg[g] <= ((wr_lane0 && awaddr_reg == poff[g]) ? wbyte : pflag_reg[g])
                               | pevent[g]; // R5 R8
            end
         end
      end
   endgenerate

   //=============================================================
   // sticky event status and mask: bit0 ext1, bit1 ext2, bits 4..2 any peripheral bank
   // a whole bank shares one status bit, so the summary needs no per-source mask
   logic [4:0] stat_reg, mask_reg;
   logic [4:0] stat_set;
   assign stat_set = {|pevent[2], |pevent[1], |pevent[0], ext_event.ext2, ext_event.ext1};
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         stat_reg <= 5'h00;
         mask_reg <= 5'h00;
      end else begin
         // write one to clear, a fresh event wins
         if (wr_lane0 && awaddr_reg == `EIC_OFF_STATUS) begin
            stat_reg <= (stat_reg & ~wbyte[4:0]) | stat_set;
         end else begin
            stat_reg <= stat_reg | stat_set;
         end
         if (wr_lane0 && awaddr_reg == `EIC_OFF_MASK) mask_reg <= wbyte[4:0];
      end
   end
   assign irq = |(stat_reg & mask_reg);

   //=============================================================
   // priority steering of the enabled pending requests
   // registered so a request never glitches while software rewrites the register
   logic req2, req1;
   assign req2 = ctrl_reg[`EIC_BIT_EXT2_PEND] & ctrl_reg[`EIC_BIT_EXT2_EN]; // R2
   assign req1 = ctrl_reg[`EIC_BIT_EXT1_PEND] & ctrl_reg[`EIC_BIT_EXT1_EN]; // R2
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         ext_req <= '0;
      end else begin
         ext_req.high <= (req2 & ctrl_reg[`EIC_BIT_EXT2_PRIO])
                       | (req1 & ctrl_reg[`EIC_BIT_EXT1_PRIO]); // R9
         ext_req.low <= (req2 & ~ctrl_reg[`EIC_BIT_EXT2_PRIO])
                      | (req1 & ~ctrl_reg[`EIC_BIT_EXT1_PRIO]); // R9
      end
   end

   //=============================================================
   // axi4-lite read channel, one cycle after address accept
   // arready drops while rvalid stands, so rdata cannot change before it is taken
   assign s_arready = !s_rvalid;
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         s_rvalid <= 1'b0;
         s_rdata <= 32'h0000_0000;
         s_rresp <= `EIC_RESP_OKAY;
      end else if (s_arvalid && s_arready) begin
         s_rvalid <= 1'b1;
         s_rresp <= addr_ok(s_araddr) ? `EIC_RESP_OKAY : `EIC_RESP_SLVERR;
         case (s_araddr)
            `EIC_OFF_CTRL: s_rdata <= {24'h000000, ctrl_reg}; // R4
            `EIC_OFF_PERIPH_A: s_rdata <= {24'h000000, pflag_reg[0]};
            `EIC_OFF_PERIPH_B: s_rdata <= {24'h000000, pflag_reg[1]};
            `EIC_OFF_PERIPH_C: s_rdata <= {24'h000000, pflag_reg[2]};
            `EIC_OFF_STATUS: s_rdata <= {27'h0000000, stat_reg};
            `EIC_OFF_MASK: s_rdata <= {27'h0000000, mask_reg};
            default: s_rdata <= 32'h0000_0000;
         endcase
      end else if (s_rvalid && s_rready) begin
         s_rvalid <= 1'b0;
      end
   end

   //=============================================================
   // checks
   // control register: unimplemented bits, pending set and hold, writes
   unused_zero_a: assert property (@(posedge clock) disable iff (!nrst) // R4
      ctrl_reg[5] == 1'b0 && ctrl_reg[2] == 1'b0) else $error("unimplemented bit set");
   pend_set_a: assert property (@(posedge clock) disable iff (!nrst) // R3
      ext_event.ext1 |=> ctrl_reg[`EIC_BIT_EXT1_PEND]) else $error("ext1 pending missed");
   pend2_set_a: assert property (@(posedge clock) disable iff (!nrst) // R5
      ext_event.ext2 |=> ctrl_reg[`EIC_BIT_EXT2_PEND]) else $error("ext2 pending missed");
   pend_hold_a: assert property (@(posedge clock) disable iff (!nrst) // R3
      ctrl_reg[`EIC_BIT_EXT1_PEND] && !wr_ctrl |=> ctrl_reg[`EIC_BIT_EXT1_PEND])
      else $error("pending dropped");
   pend2_hold_a: assert property (@(posedge clock) disable iff (!nrst) // R3
      ctrl_reg[`EIC_BIT_EXT2_PEND] && !wr_ctrl |=> ctrl_reg[`EIC_BIT_EXT2_PEND])
      else $error("ext2 pending dropped");
   enable_write_a: assert property (@(posedge clock) disable iff (!nrst) // R1
      wr_ctrl |=> ctrl_reg[`EIC_BIT_EXT1_EN] == $past(wbyte[`EIC_BIT_EXT1_EN]))
      else $error("enable not written");
   enable2_write_a: assert property (@(posedge clock) disable iff (!nrst) // R1
      wr_ctrl |=> ctrl_reg[`EIC_BIT_EXT2_EN] == $past(wbyte[`EIC_BIT_EXT2_EN]))
      else $error("ext2 enable not written");
   prio_write_a: assert property (@(posedge clock) disable iff (!nrst) // R9
      wr_ctrl |=> ctrl_reg[`EIC_BIT_EXT2_PRIO] == $past(wbyte[`EIC_BIT_EXT2_PRIO]))
      else $error("ext2 priority not written");
   prio1_write_a: assert property (@(posedge clock) disable iff (!nrst) // R9
      wr_ctrl |=> ctrl_reg[`EIC_BIT_EXT1_PRIO] == $past(wbyte[`EIC_BIT_EXT1_PRIO]))
      else $error("ext1 priority not written");
   // request steering by enable and priority
   disabled_quiet_a: assert property (@(posedge clock) disable iff (!nrst) // R2
      !ctrl_reg[`EIC_BIT_EXT1_EN] && !ctrl_reg[`EIC_BIT_EXT2_EN]
      |=> ext_req == '0) else $error("request while disabled");
   high_prio_a: assert property (@(posedge clock) disable iff (!nrst) // R9
      req1 && ctrl_reg[`EIC_BIT_EXT1_PRIO] |=> ext_req.high) else $error("high prio lost");
   low_prio_a: assert property (@(posedge clock) disable iff (!nrst) // R9
      req2 && !ctrl_reg[`EIC_BIT_EXT2_PRIO] |=> ext_req.low) else $error("low prio lost");
   ext1_low_a: assert property (@(posedge clock) disable iff (!nrst) // R9
      req1 && !ctrl_reg[`EIC_BIT_EXT1_PRIO] |=> ext_req.low) else $error("ext1 low lost");
   ext2_high_a: assert property (@(posedge clock) disable iff (!nrst) // R9
      req2 && ctrl_reg[`EIC_BIT_EXT2_PRIO] |=> ext_req.high) else $error("ext2 high lost");
   // peripheral banks and sticky status
   periph_set_a: assert property (@(posedge clock) disable iff (!nrst) // R8
      periph_event_a[0] |=> pflag_reg[0][0]) else $error("peripheral flag missed");
   periph_b_set_a: assert property (@(posedge clock) disable iff (!nrst) // R8
      pevent[1] != '0 |=> (pflag_reg[1] & $past(pevent[1])) == $past(pevent[1]))
      else $error("bank b flag missed");
   periph_c_set_a: assert property (@(posedge clock) disable iff (!nrst) // R8
      pevent[2] != '0 |=> (pflag_reg[2] & $past(pevent[2])) == $past(pevent[2]))
      else $error("bank c flag missed");
   periph_keep_a: assert property (@(posedge clock) disable iff (!nrst) // R8
      !(wr_lane0 && awaddr_reg == `EIC_OFF_PERIPH_A)
      |=> (pflag_reg[0] & $past(pflag_reg[0])) == $past(pflag_reg[0]))
      else $error("bank a flag lost");
   stat_set_a: assert property (@(posedge clock) disable iff (!nrst) // R5
      stat_set != 5'h00 |=> (stat_reg & $past(stat_set)) == $past(stat_set))
      else $error("status event missed");
   // coverage of the main scenarios
   ext_irq_cov: cover property (@(posedge clock) disable iff (!nrst) ext_req.high);
   low_irq_cov: cover property (@(posedge clock) disable iff (!nrst) ext_req.low);
   wr_rd_cov: cover property (@(posedge clock) disable iff (!nrst) wr_go ##[1:8] s_rvalid);
   irq_cov: cover property (@(posedge clock) disable iff (!nrst) irq);
   slverr_cov: cover property (@(posedge clock) disable iff (!nrst)
      s_bvalid && s_bresp == `EIC_RESP_SLVERR);
endmodule
`default_nettype wire

// *** testbench.sv ***
// self-checking bench for the external irq register bank
`timescale 1ns/10ps
`default_nettype none
`include "ext_irq_cfg.svh"
module testbench;
   import ext_irq_pkg::*;
   //==========================================
   // signals and reference model state
   logic clock, nrst, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready;
   logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, irq;
   logic [7:0] s_awaddr, s_araddr, ctrl_m, stat_m, mask_m, v;
   logic [7:0] per_m [3];
   logic [7:0] ev [3];
   logic [31:0] s_wdata, s_rdata;
   logic [3:0] s_wstrb;
   logic [1:0] s_bresp, s_rresp;
   ext_pair_t ext_pin;
   prio_req_t ext_req;
   int checks, mismatches, cycles;
   ext_irq_ctrl_bank uut (.clock(clock), .nrst(nrst), .ext_pin(ext_pin),
      .periph_event_a(ev[0]), .periph_event_b(ev[1]), .periph_event_c(ev[2]),
      .ext_req(ext_req), .irq(irq), .s_awaddr(s_awaddr), .s_awvalid(s_awvalid),
      .s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid),
      .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready),
      .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready),
      .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready));
   //==========================================
   // clock, timeout and verdict
   initial begin
      clock = 1'h0;
      forever #12.5 clock = ~clock;
   end
   task automatic complete_run;
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // a hung handshake would otherwise stall the bench forever
   always @(posedge clock) begin
      cycles++;
      if (cycles == 5000) begin
         mismatches++;
         complete_run();
      end
   end
   //==========================================
   // model of the request outputs and helper tasks
   function automatic logic [1:0] req_m(input logic [7:0] c);
      logic a2, a1;
      a2 = c[4] & c[1];
      a1 = c[3] & c[0];
      return {(a2 & c[7]) | (a1 & c[6]), (a2 & !c[7]) | (a1 & !c[6])};
   endfunction
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checks++;
      if (g !== e) begin
         mismatches++;
         $display("[ERR] t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   // address and data offered together, each dropped once taken
   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r);
      @(posedge clock);
      s_awaddr <= a;
      s_wdata <= {24'h000000, d};
      s_awvalid <= 1'h1;
      s_wvalid <= 1'h1;
      s_bready <= 1'h1;
      forever begin
         @(posedge clock);
         if (s_awready === 1'h1) s_awvalid <= 1'h0;
         if (s_wready === 1'h1) s_wvalid <= 1'h0;
         if (s_bvalid === 1'h1) break;
      end
      s_bready <= 1'h0;
      chk({30'h0, s_bresp}, {30'h0, r});
   endtask
   task automatic rc(input logic [7:0] a, input logic [7:0] e, input logic [1:0] r);
      @(posedge clock);
      s_araddr <= a;
      s_arvalid <= 1'h1;
      s_rready <= 1'h1;
      forever begin
         @(posedge clock);
         if (s_arready === 1'h1) s_arvalid <= 1'h0;
         if (s_rvalid === 1'h1) break;
      end
      s_rready <= 1'h0;
      chk(s_rdata, {24'h000000, e});
      chk({30'h0, s_rresp}, {30'h0, r});
   endtask
   // the request outputs are registered, so let a few edges pass first
   task automatic outs;
      repeat (3) @(posedge clock);
      #1;
      chk({29'h0, ext_req, irq}, {29'h0, req_m(ctrl_m), |(stat_m & mask_m)});
   endtask
   // pin held past the two-stage synchroniser
   task automatic pin(input logic p);
      @(posedge clock);
      ext_pin <= p ? 2'h2 : 2'h1;
      repeat (6) @(posedge clock);
      ext_pin <= 2'h0;
   endtask
   task automatic pev(input int b, input logic [7:0] d);
      @(posedge clock);
      ev[b] <= d;
      @(posedge clock);
      ev[b] <= 8'h00;
   endtask
   //==========================================
   // main sequence
   initial begin
      nrst = 1'h0;
      {s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = 5'h00;
      {s_awaddr, s_araddr, s_wdata} = 48'h0;
      s_wstrb = 4'h1;
      ext_pin = 2'h0;
      ev = '{default: 8'h00};
      void'($urandom(32'h6A81962A));
      repeat (8) @(posedge clock);
      nrst <= 1'h1;
      ctrl_m = 8'hC0;
      stat_m = 8'h00;
      mask_m = 8'h00;
      per_m = '{default: 8'h00};
      for (int i = 0; i < 6; i++) rc(8'(i * 4), i ? 8'h00 : 8'hC0, `EIC_RESP_OKAY);
      rc(8'h18, 8'h00, `EIC_RESP_SLVERR);
      wr(8'h18, 8'h55, `EIC_RESP_SLVERR);
      wr(`EIC_OFF_CTRL, 8'hFF, `EIC_RESP_OKAY);
      ctrl_m = 8'hDB;
      rc(`EIC_OFF_CTRL, ctrl_m, `EIC_RESP_OKAY);
      // a write whose low byte lane is not strobed leaves the register alone
      s_wstrb <= 4'hE;
      wr(`EIC_OFF_CTRL, 8'h00, `EIC_RESP_OKAY);
      s_wstrb <= 4'h1;
      rc(`EIC_OFF_CTRL, ctrl_m, `EIC_RESP_OKAY);
      outs();
      // each pin at each priority: record while disabled, then enable, then clear
      for (int k = 0; k < 4; k++) begin
         ctrl_m = k[1] ? 8'hC0 : 8'h00;
         wr(`EIC_OFF_CTRL, ctrl_m, `EIC_RESP_OKAY);
         pin(k[0]);
         ctrl_m[k[0]] = 1'h1;
         stat_m[k[0]] = 1'h1;
         rc(`EIC_OFF_CTRL, ctrl_m, `EIC_RESP_OKAY);
         outs();
         ctrl_m[k[0] ? 4 : 3] = 1'h1;
         wr(`EIC_OFF_CTRL, ctrl_m, `EIC_RESP_OKAY);
         outs();
         ctrl_m[k[0]] = 1'h0;
         wr(`EIC_OFF_CTRL, ctrl_m, `EIC_RESP_OKAY);
         outs();
      end
      rc(`EIC_OFF_STATUS, stat_m, `EIC_RESP_OKAY);
      mask_m = 8'h1F;
      wr(`EIC_OFF_MASK, mask_m, `EIC_RESP_OKAY);
      outs();
      stat_m = 8'h02;
      wr(`EIC_OFF_STATUS, 8'h01, `EIC_RESP_OKAY);
      rc(`EIC_OFF_STATUS, stat_m, `EIC_RESP_OKAY);
      mask_m = 8'h1D;
      wr(`EIC_OFF_MASK, mask_m, `EIC_RESP_OKAY);
      outs();
      stat_m = 8'h00;
      wr(`EIC_OFF_STATUS, 8'h02, `EIC_RESP_OKAY);
      outs();
      // two random event bursts per bank must accumulate
      for (int b = 0; b < 3; b++) begin
         v = 8'($urandom % 255 + 1);
         pev(b, v);
         per_m[b] = v;
         v = 8'($urandom % 255 + 1);
         pev(b, v);
         per_m[b] |= v;
         stat_m[2 + b] = 1'h1;
         rc(8'(4 + 4 * b), per_m[b], `EIC_RESP_OKAY);
         outs();
         per_m[b] = 8'h00;
         wr(8'(4 + 4 * b), 8'h00, `EIC_RESP_OKAY);
         rc(8'(4 + 4 * b), per_m[b], `EIC_RESP_OKAY);
         stat_m[2 + b] = 1'h0;
         wr(`EIC_OFF_STATUS, 8'(1 << (2 + b)), `EIC_RESP_OKAY);
         outs();
      end
      complete_run();
   end
endmodule
`default_nettype wire
